//--- pso_cfg.svh
`ifndef PSO_CFG_SVH
`define PSO_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define PSO_OFS_STATUS 8'h00
`define PSO_OFS_IOCON 8'h04
`define PSO_OFS_SNAP 8'h08
`define PSO_OFS_CTRL 8'h0c
`define PSO_OFS_DATA 8'h10
`define PSO_OFS_ACTIVE 8'h14

// ****************************************
// Status fields
// ****************************************
`define PSO_ST_EVT 15:12
`define PSO_ST_LIVE 11:8
`define PSO_ST_SW_TRIGGER_SET 7
`define PSO_ST_SW_TRIGGER_CLEAR 6
`define PSO_ST_CAP 5
`define PSO_ST_PEND 4
`define PSO_ST_RELOAD_REQUEST_STROBE 3
`define PSO_ST_STEER 2
`define PSO_ST_HALF 1
`define PSO_ST_RUN 0

// ****************************************
// Output control fields
// ****************************************
`define PSO_IO_ILIM_INV 15
`define PSO_IO_SWAP 14
`define PSO_IO_OVR_EN 13:12
`define PSO_IO_OVR_LV 11:10
`define PSO_IO_FTS 9:8
`define PSO_IO_FAULT_LV 7:6
`define PSO_IO_ILIM_LV 5:4
`define PSO_IO_FF_LV 3:2
`define PSO_IO_HALT_LV 1:0

// ****************************************
// Control fields and reset values
// ****************************************
`define PSO_CT_EN 0
`define PSO_CT_RMODE 3:1
`define PSO_CT_PP 4
`define PSO_CT_CA 5
`define PSO_IOCON_RST 16'h0000
`define PSO_CTRL_RST 6'h00

`endif

//--- pso_gate_drv.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Gate drivers: follow the pins one cycle late
// ********
module pso_gate_drv (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drive_h,
  input wire logic drive_l,
  output logic gate_h,
  output logic gate_l
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_h <= 1'b0;
      gate_l <= 1'b0;
    end
    else
    begin
      gate_h <= drive_h;
      gate_l <= drive_l;
    end
  end
endmodule

`default_nettype wire

//--- pso_out_mux.sv
`timescale 1ns/1ps
`default_nettype none

module pso_out_mux (
  input wire logic gen_h,
  input wire logic gen_l,
  input wire logic fault,
  input wire logic ilimit,
  input wire logic feedfwd,
  input wire logic halt,
  input wire logic ilim_inv,
  input wire logic swap,
  input wire logic [1:0] fault_lv,
  input wire logic [1:0] ilim_lv,
  input wire logic [1:0] ff_lv,
  input wire logic [1:0] halt_lv,
  input wire logic [1:0] ovr_en,
  input wire logic [1:0] ovr_lv,
  output logic pin_h,
  output logic pin_l
);

  // ****************************************
  // Substitution in priority order
  // ****************************************
  wire logic [1:0] gen_pair;
  wire logic [1:0] user_pair;
  wire logic [1:0] ilim_pair;
  wire logic [1:0] sel_pair;

  assign gen_pair = {gen_h, gen_l};
  assign user_pair = {ovr_en[1] ? ovr_lv[1] : gen_h,
                      ovr_en[0] ? ovr_lv[0] : gen_l}; // [R15]
  assign ilim_pair = ilim_inv ? ~gen_pair : ilim_lv; // [R13] [R18]
  assign sel_pair = fault ? fault_lv : // [R17] [R23]
                    ilimit ? ilim_pair :
                    feedfwd ? ff_lv : // [R19]
                    halt ? halt_lv : // [R20]
                    user_pair;

  // Swap follows the selection
  assign pin_h = swap ? sel_pair[0] : sel_pair[1]; // [R14] [R23]
  assign pin_l = swap ? sel_pair[1] : sel_pair[0]; // [R14]

endmodule

`default_nettype wire

//--- pso_pkg.sv
package pso_pkg;

  typedef enum logic [1:0] {
    PSO_FT_SOC = 2'b00,
    PSO_FT_IMM = 2'b01,
    PSO_FT_RELOAD = 2'b10,
    PSO_FT_RSVD = 2'b11
  } pso_force_timing_e;

  typedef enum logic [2:0] {
    PSO_RM_SOC = 3'b000,
    PSO_RM_IMM = 3'b001,
    PSO_RM_SLV_SOC = 3'b010,
    PSO_RM_SLV_IMM = 3'b011
  } pso_reload_mode_e;

endpackage

//--- pso_status_override.sv
`timescale 1ns/1ps
`default_nettype none
`include "pso_cfg.svh"

// Summary of operation
// [R01] Sync and fault flags set on edge/enable
// [R02] Ilimit and feedfwd flags set likewise
// [R03] Four live input bits readable
// [R04] Trigger-set write starts cycle, reads zero
// [R05] Trigger-clear write without trigger-set stops cycle, reads zero
// [R06] Capture request snapshots time base, sets flag
// [R07] No further capture until flag cleared
// [R08] Pending update blocks user data writes
// [R09] Reload strobe sets pending, reads zero
// [R10] Push-pull steering bit reported
// [R11] Centre-aligned half bit reported
// [R12] Running flag shows cycle in progress
// [R13] Ilimit invert mode flips both outputs
// [R14] Swap exchanges high and low pins
// [R15] Per-pin user force levels
// [R16] Force timing: cycle start, immediate, reload
// [R17] Fault drives fault levels
// [R18] Ilimit drives ilimit levels when not inverting
// [R19] Feedfwd drives feedfwd levels
// [R20] Debug halt drives halt levels
// [R21] Default mode reloads at cycle start
// [R22] Immediate mode reloads at once
// [R23] Priority fault, ilimit, feedfwd, halt, user; swap last
// [R24] Status writes never set event flags
module pso_status_override #(
  parameter int DATA_W = 16,
  parameter int TB_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_pin,
  input wire logic fault_pin,
  input wire logic ilimit_pin,
  input wire logic feedfwd_pin,
  input wire logic halt_pin,
  input wire logic [TB_W-1:0] timebase,
  input wire logic soc_pulse,
  input wire logic cycle_end,
  input wire logic steer_in,
  input wire logic half_in,
  input wire logic pwm_h_gen,
  input wire logic pwm_l_gen,
  output logic high_side_output,
  output logic low_side_output,
  output logic trigger_start,
  output logic trigger_stop,
  output logic reload_strobe,
  output logic [DATA_W-1:0] active_data
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Order: sync, fault, ilimit, feedfwd
  logic [3:0] pci_meta, pci_sync, pci_prev;
  logic halt_meta, halt_sync;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pci_meta <= 4'h0;
      pci_sync <= 4'h0;
      pci_prev <= 4'h0;
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end
    else if (pce)
    begin
      pci_meta <= {sync_pin, fault_pin, ilimit_pin, feedfwd_pin};
      pci_sync <= pci_meta;
      pci_prev <= pci_sync;
      halt_meta <= halt_pin;
      halt_sync <= halt_meta;
    end
  end

  // ****************************************
  // State
  // ****************************************
  logic [3:0] evt_flag;
  logic cap_flag, pending, running, en_prev;
  logic [15:0] iocon;
  logic [5:0] ctrl;
  logic [TB_W-1:0] snapshot;
  logic [DATA_W-1:0] data_buf;
  logic [1:0] ovr_en, ovr_lv;

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic acc, wr, mapped, refused;
  wire logic sel_stat, sel_io, sel_snap, sel_ctrl, sel_data, sel_act;
  wire logic wr_stat, wr_io, wr_ctrl, wr_data;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign sel_stat = paddr == `PSO_OFS_STATUS;
  assign sel_io = paddr == `PSO_OFS_IOCON;
  assign sel_snap = paddr == `PSO_OFS_SNAP;
  assign sel_ctrl = paddr == `PSO_OFS_CTRL;
  assign sel_data = paddr == `PSO_OFS_DATA;
  assign sel_act = paddr == `PSO_OFS_ACTIVE;
  assign mapped = sel_stat | sel_io | sel_snap | sel_ctrl | sel_data | sel_act;
  assign wr_stat = wr & sel_stat;
  assign wr_io = wr & sel_io;
  assign wr_ctrl = wr & sel_ctrl;
  assign wr_data = wr & sel_data & ~pending; // [R08]
  assign refused = pwrite & sel_data & pending;

  // ****************************************
  // Next-state terms
  // ****************************************
  pso_pkg::pso_reload_mode_e rmode;
  pso_pkg::pso_force_timing_e ftime;
  wire logic en_rise, cap_req, cap_clr, trg_set, trg_clr, upd_req, xfer, ovr_apply;
  wire logic next_cap, next_running, next_pending;
  wire logic [3:0] evt_set, evt_clr, next_evt;
  assign rmode = pso_pkg::pso_reload_mode_e'(ctrl[`PSO_CT_RMODE]);
  assign ftime = pso_pkg::pso_force_timing_e'(iocon[`PSO_IO_FTS]);
  assign en_rise = ctrl[`PSO_CT_EN] & ~en_prev;
  // Edge, or already high as the module comes on
  assign evt_set = (pci_sync & ~pci_prev) | (pci_sync & {4{en_rise}}); // [R01] [R02]
  assign evt_clr = {4{wr_stat}} & ~pwdata[`PSO_ST_EVT]; // [R24]
  assign next_evt = evt_set | (evt_flag & ~evt_clr); // [R01] [R02] [R24]
  assign cap_req = wr_stat & pwdata[`PSO_ST_CAP] & ~cap_flag; // [R06] [R07]
  assign cap_clr = wr_stat & ~pwdata[`PSO_ST_CAP];
  assign next_cap = cap_req | (cap_flag & ~cap_clr); // [R24]
  assign trg_set = wr_stat & pwdata[`PSO_ST_SW_TRIGGER_SET];
  assign trg_clr = wr_stat & pwdata[`PSO_ST_SW_TRIGGER_CLEAR];
  assign next_running = trg_set | (running & ~trg_clr & ~cycle_end); // [R04] [R05] [R12]
  assign upd_req = wr_stat & pwdata[`PSO_ST_RELOAD_REQUEST_STROBE]; // [R09]
  // Slaved modes have no master here; they wait for cycle start
  assign xfer = pending & ((rmode == pso_pkg::PSO_RM_IMM) | soc_pulse); // [R21] [R22]
  assign next_pending = upd_req | (pending & ~xfer); // [R09] [R21]
  assign ovr_apply = (ftime == pso_pkg::PSO_FT_IMM) |
                     ((ftime == pso_pkg::PSO_FT_SOC) & soc_pulse) |
                     ((ftime == pso_pkg::PSO_FT_RELOAD) & xfer); // [R16]

  // ****************************************
  // Read mux
  // ****************************************
  logic [31:0] rd_data;
  wire logic [15:0] status_word;

  assign status_word = {evt_flag, pci_sync, 2'b00, cap_flag, pending, 1'b0,
                        steer_in & ctrl[`PSO_CT_PP], // [R10]
                        half_in & ctrl[`PSO_CT_CA], // [R11]
                        running}; // [R03] [R12]
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (sel_stat)
      rd_data = {16'h0000, status_word};
    else if (sel_io)
      rd_data = {16'h0000, iocon};
    else if (sel_snap)
      rd_data[TB_W-1:0] = snapshot;
    else if (sel_ctrl)
      rd_data = {26'h000_0000, ctrl};
    else if (sel_data)
      rd_data[DATA_W-1:0] = data_buf;
    else if (sel_act)
      rd_data[DATA_W-1:0] = active_data;
  end

  // ****************************************
  // Bus answer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (pce)
    begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= ~mapped | refused; // [R08]
      end
      else if (acc)
      begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status and control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_flag <= 4'h0;
      cap_flag <= 1'b0;
      pending <= 1'b0;
      running <= 1'b0;
      en_prev <= 1'b0;
      iocon <= `PSO_IOCON_RST;
      ctrl <= `PSO_CTRL_RST;
      snapshot <= '0;
      data_buf <= '0;
      active_data <= '0;
      ovr_en <= 2'b00;
      ovr_lv <= 2'b00;
    end
    else if (pce)
    begin
      evt_flag <= next_evt;
      cap_flag <= next_cap;
      pending <= next_pending;
      running <= next_running;
      en_prev <= ctrl[`PSO_CT_EN];
      if (wr_io)
        iocon <= pwdata[15:0];
      if (wr_ctrl)
        ctrl <= pwdata[5:0];
      if (cap_req)
        snapshot <= timebase; // [R06]
      if (wr_data)
        data_buf <= pwdata[DATA_W-1:0];
      if (xfer)
        active_data <= data_buf; // [R21] [R22]
      if (ovr_apply)
      begin
        ovr_en <= iocon[`PSO_IO_OVR_EN];
        ovr_lv <= iocon[`PSO_IO_OVR_LV];
      end
    end
  end

  // ****************************************
  // Output substitution and strobes
  // ****************************************
  wire logic pin_h, pin_l;
  pso_out_mux pso_out_mux_inst (
    .gen_h(pwm_h_gen), .gen_l(pwm_l_gen), .fault(pci_sync[2]), .ilimit(pci_sync[1]),
    .feedfwd(pci_sync[0]), .halt(halt_sync), .ilim_inv(iocon[`PSO_IO_ILIM_INV]),
    .swap(iocon[`PSO_IO_SWAP]), .fault_lv(iocon[`PSO_IO_FAULT_LV]),
    .ilim_lv(iocon[`PSO_IO_ILIM_LV]), .ff_lv(iocon[`PSO_IO_FF_LV]),
    .halt_lv(iocon[`PSO_IO_HALT_LV]), .ovr_en(ovr_en), .ovr_lv(ovr_lv),
    .pin_h(pin_h), .pin_l(pin_l)
  );
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_side_output <= 1'b0;
      low_side_output <= 1'b0;
      trigger_start <= 1'b0;
      trigger_stop <= 1'b0;
      reload_strobe <= 1'b0;
    end
    else if (pce)
    begin
      high_side_output <= pin_h;
      low_side_output <= pin_l;
      trigger_start <= trg_set; // [R04]
      trigger_stop <= trg_clr & ~trg_set; // [R05]
      reload_strobe <= xfer;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_sync_edge_sets;
    @(posedge pclk) disable iff (!presetn)
    (pce && pci_sync[3] && !pci_prev[3]) |=> evt_flag[3];
  endproperty
  a_sync_edge_sets: assert property (p_sync_edge_sets) // [R01]
    else $error("sync edge did not set flag");
  property p_ilim_edge_sets;
    @(posedge pclk) disable iff (!presetn)
    (pce && pci_sync[1] && !pci_prev[1]) |=> evt_flag[1];
  endproperty
  a_ilim_edge_sets: assert property (p_ilim_edge_sets) // [R02]
    else $error("ilimit edge did not set flag");
  property p_live_read;
    @(posedge pclk) disable iff (!presetn)
    (pce && psel && !penable && !pwrite && sel_stat && !pready)
      |=> prdata[11:8] == $past(pci_sync) && prdata[7:6] == 2'b00 && prdata[3] == 1'b0;
  endproperty
  a_live_read: assert property (p_live_read) // [R03]
    else $error("live bits or strobe bits wrong on read");
  property p_cycle_running_flag_set;
    @(posedge pclk) disable iff (!presetn)
    (pce && wr_stat && pwdata[`PSO_ST_SW_TRIGGER_SET]) |=> running && trigger_start;
  endproperty
  a_cycle_running_flag_set: assert property (p_cycle_running_flag_set) // [R04]
    else $error("trigger set did not start cycle");
  property p_cycle_running_flag_clr;
    @(posedge pclk) disable iff (!presetn)
    (pce && wr_stat && pwdata[`PSO_ST_SW_TRIGGER_CLEAR] && !pwdata[`PSO_ST_SW_TRIGGER_SET])
      |=> !running && trigger_stop;
  endproperty
  a_cycle_running_flag_clr: assert property (p_cycle_running_flag_clr) // [R05]
    else $error("trigger clear did not stop cycle");
  property p_capture;
    @(posedge pclk) disable iff (!presetn)
    (pce && cap_req) |=> cap_flag && snapshot == $past(timebase);
  endproperty
  a_capture: assert property (p_capture) // [R06]
    else $error("capture did not snapshot time base");
  property p_capture_block;
    @(posedge pclk) disable iff (!presetn)
    (pce && cap_flag && !cap_clr) |=> cap_flag && $stable(snapshot);
  endproperty
  a_capture_block: assert property (p_capture_block) // [R07]
    else $error("second capture while flag set");
  property p_write_blocked;
    @(posedge pclk) disable iff (!presetn)
    (pce && pending && wr && sel_data) |=> $stable(data_buf);
  endproperty
  a_write_blocked: assert property (p_write_blocked) // [R08]
    else $error("data written while update pending");
  property p_reload_req;
    @(posedge pclk) disable iff (!presetn)
    (pce && upd_req) |=> pending;
  endproperty
  a_reload_req: assert property (p_reload_req) // [R09]
    else $error("reload request lost");
  property p_soc_reload;
    @(posedge pclk) disable iff (!presetn)
    (pce && pending && rmode == pso_pkg::PSO_RM_SOC && soc_pulse && !upd_req)
      |=> !pending && active_data == $past(data_buf) && reload_strobe;
  endproperty
  a_soc_reload: assert property (p_soc_reload) // [R21]
    else $error("cycle-start reload missing");
  property p_fault_level;
    @(posedge pclk) disable iff (!presetn)
    (pce && pci_sync[2] && !iocon[`PSO_IO_SWAP])
      |=> high_side_output == $past(iocon[7]) && low_side_output == $past(iocon[6]);
  endproperty
  a_fault_level: assert property (p_fault_level) // [R17]
    else $error("fault levels not driven");
  property p_no_sw_set;
    @(posedge pclk) disable iff (!presetn)
    (pce && evt_set == 4'h0) |=> (evt_flag & ~$past(evt_flag)) == 4'h0;
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) // [R24]
    else $error("event flag set without event");

endmodule

`default_nettype wire

//--- tb_pwm_status_output_override.sv
`timescale 1ns/1ps
`default_nettype none
`include "pso_cfg.svh"

module tb_pwm_status_output_override;
  logic pclk, presetn, pce, psel, penable, pwrite, probe, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic high_side_output, low_side_output, gate_h, gate_l;
  logic sync_pin, fault_pin, ilimit_pin, feedfwd_pin, halt_pin;
  logic soc_pulse, cycle_end, steer_in, half_in, pwm_h_gen, pwm_l_gen;
  logic [15:0] timebase, active_data, tbv, dv, dv2;
  logic [32:0] got;
  logic [32:0] exp_q[$], msk_q[$];
  int failures = 0;
  int compares = 0;
  int i;

  pso_status_override pso_status_override_inst (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_pin(sync_pin), .fault_pin(fault_pin),
    .ilimit_pin(ilimit_pin), .feedfwd_pin(feedfwd_pin), .halt_pin(halt_pin),
    .timebase(timebase), .soc_pulse(soc_pulse), .cycle_end(cycle_end),
    .steer_in(steer_in), .half_in(half_in), .pwm_h_gen(pwm_h_gen), .pwm_l_gen(pwm_l_gen),
    .high_side_output(high_side_output), .low_side_output(low_side_output),
    .trigger_start(), .trigger_stop(), .reload_strobe(), .active_data(active_data)
  );

  pso_gate_drv pso_gate_drv_inst (
    .pclk(pclk), .presetn(presetn), .drive_h(high_side_output),
    .drive_l(low_side_output), .gate_h(gate_h), .gate_l(gate_l)
  );

  always #2.5 pclk = ~pclk;

  // ********
  // Result watcher
  // ********
  always @(posedge pclk)
  begin
    if ((psel && penable && pready) === 1'b1 || probe === 1'b1)
    begin
      got = probe ? {31'h0, gate_h, gate_l} : {pslverr, prdata};
      compares++;
      if ((got & msk_q[0]) !== (exp_q[0] & msk_q[0]))
      begin
        failures++;
        $display("[FAIL] t=%0t got %h exp %h", $time, got & msk_q[0], exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // ********
  // Bus and pin tasks
  // ********
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    int n = 0;
    exp_q.push_back(e);
    msk_q.push_back(m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e, {33{1'b1}});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic pulse_soc();
    soc_pulse <= 1'b1;
    @(posedge pclk);
    soc_pulse <= 1'b0;
    idle(4);
  endtask

  task automatic chk_pins(input logic [1:0] e);
    exp_q.push_back({31'h0, e});
    msk_q.push_back(33'h3);
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pin_case(input logic [15:0] io, input logic [3:0] p, input logic [1:0] g,
                          input logic [1:0] e);
    wr(`PSO_OFS_IOCON, {16'h0, io});
    {fault_pin, ilimit_pin, feedfwd_pin, halt_pin} <= p;
    {pwm_h_gen, pwm_l_gen} <= g;
    idle(6);
    chk_pins(e);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    conclude();
  end

  // ********
  // Main sequence
  // ********
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, probe, soc_pulse, cycle_end} = '0;
    {sync_pin, fault_pin, ilimit_pin, feedfwd_pin, halt_pin, steer_in, half_in} = '0;
    {pwm_h_gen, pwm_l_gen, paddr, pwdata, timebase} = '0;
    pce = 1'b1;
    void'($urandom(14));
    idle(12);
    presetn <= 1'b1;
    idle(1);
    rd(`PSO_OFS_STATUS, 33'h0);
    rd(`PSO_OFS_IOCON, 33'h0);
    rd(8'h18, 33'h1_0000_0000);
    note("reset");
    sync_pin <= 1'b1;
    idle(6);
    wr(`PSO_OFS_STATUS, 32'h0);
    rd(`PSO_OFS_STATUS, 33'h0800);
    wr(`PSO_OFS_CTRL, 32'h1);
    rd(`PSO_OFS_STATUS, 33'h8800);
    sync_pin <= 1'b0;
    idle(6);
    wr(`PSO_OFS_STATUS, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      {sync_pin, fault_pin, ilimit_pin, feedfwd_pin} <= 4'h8 >> i;
      idle(6);
      rd(`PSO_OFS_STATUS, {17'h0, 4'h8 >> i, 4'h8 >> i, 8'h00});
      {sync_pin, fault_pin, ilimit_pin, feedfwd_pin} <= 4'h0;
      idle(6);
      wr(`PSO_OFS_STATUS, 32'hf000);
      rd(`PSO_OFS_STATUS, {17'h0, 4'h8 >> i, 12'h000});
      wr(`PSO_OFS_STATUS, 32'h0);
      rd(`PSO_OFS_STATUS, 33'h0);
    end
    wr(`PSO_OFS_STATUS, 32'hf000);
    rd(`PSO_OFS_STATUS, 33'h0);
    note("events");
    wr(`PSO_OFS_STATUS, 32'h80);
    rd(`PSO_OFS_STATUS, 33'h1);
    cycle_end <= 1'b1;
    idle(1);
    cycle_end <= 1'b0;
    idle(2);
    rd(`PSO_OFS_STATUS, 33'h0);
    wr(`PSO_OFS_STATUS, 32'hc0);
    rd(`PSO_OFS_STATUS, 33'h1);
    wr(`PSO_OFS_STATUS, 32'h40);
    rd(`PSO_OFS_STATUS, 33'h0);
    note("trigger");
    tbv = 16'($urandom);
    timebase <= tbv;
    idle(1);
    wr(`PSO_OFS_STATUS, 32'h20);
    rd(`PSO_OFS_SNAP, {17'h0, tbv});
    rd(`PSO_OFS_STATUS, 33'h20);
    timebase <= ~tbv;
    wr(`PSO_OFS_STATUS, 32'h20);
    rd(`PSO_OFS_SNAP, {17'h0, tbv});
    wr(`PSO_OFS_STATUS, 32'h0);
    wr(`PSO_OFS_STATUS, 32'h20);
    rd(`PSO_OFS_SNAP, {17'h0, ~tbv});
    wr(`PSO_OFS_STATUS, 32'h0);
    note("capture");
    dv = 16'($urandom);
    dv2 = ~dv;
    wr(`PSO_OFS_CTRL, 32'h3);
    wr(`PSO_OFS_DATA, {16'h0, dv});
    wr(`PSO_OFS_STATUS, 32'h8);
    rd(`PSO_OFS_ACTIVE, {17'h0, dv});
    rd(`PSO_OFS_STATUS, 33'h0);
    wr(`PSO_OFS_CTRL, 32'h1);
    wr(`PSO_OFS_DATA, {16'h0, dv2});
    wr(`PSO_OFS_STATUS, 32'h8);
    rd(`PSO_OFS_STATUS, 33'h10);
    apb(1'b1, `PSO_OFS_DATA, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    rd(`PSO_OFS_ACTIVE, {17'h0, dv});
    pulse_soc();
    rd(`PSO_OFS_ACTIVE, {17'h0, dv2});
    rd(`PSO_OFS_STATUS, 33'h0);
    note("reload");
    wr(`PSO_OFS_CTRL, 32'h31);
    {steer_in, half_in} <= 2'b11;
    rd(`PSO_OFS_STATUS, 33'h6);
    wr(`PSO_OFS_CTRL, 32'h1);
    rd(`PSO_OFS_STATUS, 33'h0);
    {steer_in, half_in} <= 2'b00;
    note("phase");
    pin_case(16'h0000, 4'b0000, 2'b10, 2'b10);
    pin_case(16'h4000, 4'b0000, 2'b10, 2'b01);
    pin_case(16'h0040, 4'b1110, 2'b10, 2'b01);
    pin_case(16'h8030, 4'b0100, 2'b10, 2'b01);
    pin_case(16'h0020, 4'b0110, 2'b01, 2'b10);
    pin_case(16'h0004, 4'b0010, 2'b10, 2'b01);
    pin_case(16'h0002, 4'b0001, 2'b01, 2'b10);
    pin_case(16'h3500, 4'b0000, 2'b10, 2'b01);
    pin_case(16'h7900, 4'b0000, 2'b01, 2'b01);
    pin_case(16'h3502, 4'b0001, 2'b00, 2'b10);
    pin_case(16'h0100, 4'b0000, 2'b00, 2'b00);
    pin_case(16'h3c00, 4'b0000, 2'b00, 2'b00);
    pulse_soc();
    chk_pins(2'b11);
    wr(`PSO_OFS_CTRL, 32'h3);
    pin_case(16'h3600, 4'b0000, 2'b00, 2'b11);
    wr(`PSO_OFS_STATUS, 32'h8);
    idle(4);
    chk_pins(2'b01);
    note("outputs");
    pin_case(16'h0100, 4'b0000, 2'b10, 2'b10);
    pce <= 1'b0;
    {pwm_h_gen, pwm_l_gen} <= 2'b01;
    idle(6);
    chk_pins(2'b10);
    pce <= 1'b1;
    idle(4);
    chk_pins(2'b01);
    note("clock enable");
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    idle(1);
    rd(`PSO_OFS_IOCON, 33'h0);
    rd(`PSO_OFS_CTRL, 33'h0);
    note("second reset");
    idle(4);
    conclude();
  end
endmodule

`default_nettype wire
